// ===== src/startup_seq_pkg.sv
// Purpose: shared constants and helpers for the link start-up sequencer
// Assumes: 200 MHz system clock, 32-bit AXI4-Lite register bus
// Notes:   times are held in ms, cycle counts derived from them
package startup_seq_pkg;
  // ==========================================================
  // states
  typedef enum logic [2:0] {
    ST_STANDBY, ST_L1_SYNC, ST_PROTO, ST_CM_SETUP, ST_VENDOR
  } seq_state_t;

  // ==========================================================
  // widths
  localparam int RATE_W = 8;
  localparam int VER_W  = 8;
  localparam int RI_W   = $clog2(RATE_W);
  localparam int ADDR_W = 8;

  // ==========================================================
  // timing
  localparam int CLK_MHZ         = 200;
  localparam int CYC_PER_MS      = CLK_MHZ * 1000;
  localparam int MASTER_DWELL_MS = 1000;
  localparam int SLAVE_DWELL_MS  = 4000;
  localparam int EVAL_MS         = 50;
  localparam int SUP_MS          = 10000;
  localparam int MASTER_DWELL_CYC = MASTER_DWELL_MS * CYC_PER_MS;
  localparam int SLAVE_DWELL_CYC  = SLAVE_DWELL_MS * CYC_PER_MS;
  localparam int EVAL_CYC         = EVAL_MS * CYC_PER_MS;
  localparam int SUP_CYC          = SUP_MS * CYC_PER_MS;

  // ==========================================================
  // register map
  localparam logic [ADDR_W-1:0] A_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] A_RATEMASK = 8'h04;
  localparam logic [ADDR_W-1:0] A_VERMASK  = 8'h08;
  localparam logic [ADDR_W-1:0] A_CMRATES  = 8'h0C;
  localparam logic [ADDR_W-1:0] A_STATUS   = 8'h10;
  localparam logic [ADDR_W-1:0] A_RESTARTS = 8'h14;
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam int CM_HDLC_LSB     = 0;
  localparam int CM_ETH_LSB      = 8;
  localparam logic [RATE_W-1:0] RATEMASK_RST = 8'h01;
  localparam logic [VER_W-1:0]  VERMASK_RST  = 8'h01;
  localparam logic [2:0] HDLC_RST = 3'h0;
  localparam logic [5:0] ETH_RST  = 6'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // helpers
  function automatic logic [RI_W-1:0] top_bit(
      input logic [RATE_W-1:0] m);
    logic [RI_W-1:0] r;
    r = '0;
    for (int i = 0; i < RATE_W; i++) begin
      if (m[i]) r = RI_W'(i);
    end
    return r;
  endfunction

  // next slower allowed rate, wrapping to the fastest
  function automatic logic [RI_W-1:0] next_rate(
      input logic [RATE_W-1:0] m, input logic [RI_W-1:0] cur);
    logic [RI_W-1:0] r;
    logic            found;
    r = top_bit(m);
    found = 1'b0;
    for (int i = RATE_W - 1; i >= 0; i--) begin
      if (!found && m[i] && RI_W'(i) < cur) begin
        r = RI_W'(i);
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // version n is allowed when mask bit n-1 is set
  function automatic logic [7:0] top_ver(input logic [VER_W-1:0] m);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < VER_W; i++) begin
      if (m[i]) v = 8'(i + 1);
    end
    return v;
  endfunction

  function automatic logic [7:0] pick_ver(
      input logic [VER_W-1:0] m, input logic [7:0] rxv);
    logic [7:0] b;
    logic [7:0] l;
    b = 8'h00;
    l = 8'h00;
    for (int i = VER_W - 1; i >= 0; i--) begin
      if (m[i]) begin
        l = 8'(i + 1);
        if (b == 8'h00 && 8'(i + 1) <= rxv) b = 8'(i + 1);
      end
    end
    return (b != 8'h00) ? b : l;
  endfunction

  function automatic logic [7:0] maj3(
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    return (a & b) | (a & c) | (b & c);
  endfunction
endpackage

// ===== src/startup_seq.sv
// Purpose: start-up sequencer for one port of a serial radio link
// Assumes: all inputs synchronous to sys_clk; phy does the framing
// Notes:   registers over AXI4-Lite, all state in one struct
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module startup_seq
  import startup_seq_pkg::*;
#(
  parameter int MASTER_DWELL = MASTER_DWELL_CYC,
  parameter int SLAVE_DWELL  = SLAVE_DWELL_CYC,
  parameter int EVAL_PERIOD  = EVAL_CYC,
  parameter int SUP_TIMEOUT  = SUP_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              hyperframe_lock_state,
  input  wire logic              far_hf_lock,
  input  wire logic              rx_hf_strobe,
  input  wire logic [7:0]        rx_version,
  input  wire logic              slave_in_vendor,
  input  wire logic              cm_rate_agreed,
  input  wire logic              cm_link_up,
  output logic                   tx_enable,
  output logic                   rx_enable,
  output logic [RI_W-1:0]        tx_rate_idx,
  output logic [RI_W-1:0]        rx_rate_idx,
  output logic [7:0]             tx_version,
  output logic [2:0]             tx_hdlc_rate,
  output logic [5:0]             tx_eth_rate,
  output logic [2:0]             seq_state,
  output logic                   port_is_master,
  output logic                   sup_restart
);

  // ==========================================================
  // state
  typedef struct packed {
    seq_state_t        st;
    logic              start;
    logic              master;
    logic [RATE_W-1:0] rmask;
    logic [VER_W-1:0]  vmask;
    logic [2:0]        hdlc;
    logic [5:0]        eth;
    logic [RI_W-1:0]   rate;
    logic [7:0]        ver;
    logic [31:0]       dwell;
    logic [31:0]       eval;
    logic [31:0]       sup;
    logic              sup_run;
    logic [7:0]        s0;
    logic [7:0]        s1;
    logic [7:0]        s2;
    logic              tx_en;
    logic              rx_en;
    logic              restart;
    logic [15:0]       restarts;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awa;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } regs_t;

  regs_t r_ff;
  regs_t nxt_r;

  // entry into line-rate sync: fastest rate, timer idle
  function automatic regs_t enter_l1(input regs_t r);
    regs_t n;
    n = r;
    n.st = ST_L1_SYNC;
    n.rate = top_bit(r.rmask);
    n.dwell = 32'h0;
    n.rx_en = 1'b1;
    n.tx_en = r.master;
    n.ver = top_ver(r.vmask);
    n.sup_run = 1'b0;
    n.sup = 32'h0;
    return n;
  endfunction

  // ==========================================================
  // outputs
  assign s_axi_awready  = !r_ff.aw_got && !r_ff.bvalid;
  assign s_axi_wready   = !r_ff.w_got && !r_ff.bvalid;
  assign s_axi_arready  = !r_ff.rvalid;
  assign s_axi_bvalid   = r_ff.bvalid;
  assign s_axi_bresp    = r_ff.bresp;
  assign s_axi_rvalid   = r_ff.rvalid;
  assign s_axi_rdata    = r_ff.rdata;
  assign s_axi_rresp    = r_ff.rresp;
  assign tx_enable      = r_ff.tx_en;
  assign rx_enable      = r_ff.rx_en;
  assign tx_rate_idx    = r_ff.rate;
  assign rx_rate_idx    = r_ff.rate;
  assign tx_version     = r_ff.ver;
  assign tx_hdlc_rate   = r_ff.hdlc;
  assign tx_eth_rate    = r_ff.eth;
  assign seq_state      = r_ff.st;
  assign port_is_master = r_ff.master;
  assign sup_restart    = r_ff.restart;

  // ==========================================================
  // next state
  always_comb begin
    logic [7:0]  rxv;
    logic [31:0] lim;
    logic        tick;
    logic        sup_exp;
    nxt_r = r_ff;
    nxt_r.restart = 1'b0;
    rxv = maj3(r_ff.s0, r_ff.s1, r_ff.s2);
    lim = r_ff.master ? 32'(MASTER_DWELL) : 32'(SLAVE_DWELL);
    tick = r_ff.eval == 32'(EVAL_PERIOD - 1);
    sup_exp = r_ff.sup_run && r_ff.sup == 32'(SUP_TIMEOUT - 1);

    // bus write
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_r.aw_got = 1'b1;
      nxt_r.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_r.w_got = 1'b1;
      nxt_r.wd = s_axi_wdata;
      nxt_r.ws = s_axi_wstrb;
    end
    if (r_ff.aw_got && r_ff.w_got) begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = RESP_OKAY;
      if (r_ff.awa == A_CTRL) begin
        if (r_ff.ws[0]) begin
          nxt_r.start = r_ff.wd[CTRL_START_BIT];
          nxt_r.master = r_ff.wd[CTRL_MASTER_BIT];
        end
      end else if (r_ff.awa == A_RATEMASK) begin
        if (r_ff.ws[0]) nxt_r.rmask = r_ff.wd[RATE_W-1:0];
      end else if (r_ff.awa == A_VERMASK) begin
        if (r_ff.ws[0]) nxt_r.vmask = r_ff.wd[VER_W-1:0];
      end else if (r_ff.awa == A_CMRATES) begin
        if (r_ff.ws[0]) nxt_r.hdlc = r_ff.wd[CM_HDLC_LSB+:3];
        if (r_ff.ws[1]) nxt_r.eth = r_ff.wd[CM_ETH_LSB+:6];
      end else if (r_ff.awa != A_STATUS && r_ff.awa != A_RESTARTS) begin
        nxt_r.bresp = RESP_SLVERR;
      end
    end
    if (r_ff.bvalid && s_axi_bready) nxt_r.bvalid = 1'b0;

    // bus read
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp = RESP_OKAY;
      nxt_r.rdata = 32'h0;
      if (s_axi_araddr == A_CTRL) begin
        nxt_r.rdata[CTRL_START_BIT] = r_ff.start;
        nxt_r.rdata[CTRL_MASTER_BIT] = r_ff.master;
      end else if (s_axi_araddr == A_RATEMASK) begin
        nxt_r.rdata[RATE_W-1:0] = r_ff.rmask;
      end else if (s_axi_araddr == A_VERMASK) begin
        nxt_r.rdata[VER_W-1:0] = r_ff.vmask;
      end else if (s_axi_araddr == A_CMRATES) begin
        nxt_r.rdata[CM_HDLC_LSB+:3] = r_ff.hdlc;
        nxt_r.rdata[CM_ETH_LSB+:6] = r_ff.eth;
      end else if (s_axi_araddr == A_STATUS) begin
        nxt_r.rdata = {5'h00, r_ff.sup_run, r_ff.rx_en, r_ff.tx_en,
                       r_ff.ver, 5'h00, r_ff.rate, 5'h00, r_ff.st};
      end else if (s_axi_araddr == A_RESTARTS) begin
        nxt_r.rdata[15:0] = r_ff.restarts;
      end else begin
        nxt_r.rresp = RESP_SLVERR;
      end
    end else if (r_ff.rvalid && s_axi_rready) begin
      nxt_r.rvalid = 1'b0;
    end

    // three-deep history, one sample per hyperframe
    if (rx_hf_strobe) begin
      nxt_r.s2 = r_ff.s1;
      nxt_r.s1 = r_ff.s0;
      nxt_r.s0 = rx_version;
    end
    nxt_r.eval = tick ? 32'h0 : r_ff.eval + 32'h1;
    nxt_r.dwell = r_ff.dwell + 32'h1;
    if (r_ff.sup_run) nxt_r.sup = r_ff.sup + 32'h1;

    // ==========================================================
    // sequencer
    case (r_ff.st)
      ST_STANDBY: begin
        nxt_r.tx_en = 1'b0;
        nxt_r.rx_en = 1'b0;
        if (r_ff.start && (!r_ff.master || slave_in_vendor)) begin
          nxt_r = enter_l1(nxt_r);
        end
      end
      ST_L1_SYNC: begin
        // slave sends only once its receiver is locked
        if (!r_ff.master) nxt_r.tx_en = hyperframe_lock_state;
        if (hyperframe_lock_state && far_hf_lock) begin
          nxt_r.st = ST_PROTO;
          if (r_ff.master) nxt_r.ver = top_ver(r_ff.vmask);
          nxt_r.tx_en = 1'b1;
          nxt_r.sup = 32'h0;
          nxt_r.sup_run = 1'b1;
          nxt_r.eval = 32'h0;
        end else if (!hyperframe_lock_state && r_ff.dwell >= lim - 1) begin
          nxt_r.rate = next_rate(r_ff.rmask, r_ff.rate);
          nxt_r.dwell = 32'h0;
        end
      end
      ST_PROTO: begin
        if (!hyperframe_lock_state) begin
          nxt_r = enter_l1(nxt_r);
        end else if (tick && rxv != 8'h00) begin
          if (rxv == r_ff.ver) begin
            nxt_r.st = ST_CM_SETUP;
          end else begin
            nxt_r.ver = pick_ver(r_ff.vmask, rxv);
          end
        end
      end
      ST_CM_SETUP, ST_VENDOR: begin
        if (!hyperframe_lock_state) begin
          nxt_r = enter_l1(nxt_r);
        end else if (tick && rxv != r_ff.ver) begin
          nxt_r.st = ST_PROTO;
        end else if (r_ff.st == ST_CM_SETUP) begin
          if (cm_rate_agreed) nxt_r.st = ST_VENDOR;
        end else if (cm_link_up) begin
          nxt_r.sup_run = 1'b0;
        end
      end
      default: nxt_r.st = ST_STANDBY;
    endcase

    // expiry wins over any step taken above
    if (sup_exp) begin
      nxt_r = enter_l1(nxt_r);
      nxt_r.restart = 1'b1;
      nxt_r.restarts = r_ff.restarts + 16'h1;
    end
    if (!r_ff.start) begin
      nxt_r.st = ST_STANDBY;
      nxt_r.tx_en = 1'b0;
      nxt_r.rx_en = 1'b0;
      nxt_r.sup_run = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      r_ff <= '0;
      r_ff.rmask <= RATEMASK_RST;
      r_ff.vmask <= VERMASK_RST;
      r_ff.hdlc <= HDLC_RST;
      r_ff.eth <= ETH_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

endmodule // startup_seq
`default_nettype wire

// ===== verif/startup_seq_properties.sv
// Purpose: port-level checks for the start-up sequencer
// Assumes: one clock domain, sync active-low reset
// Notes:   sees design ports only, bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module startup_seq_properties
  import startup_seq_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            nrst,
  input wire logic [2:0]      seq_state,
  input wire logic            port_is_master,
  input wire logic            tx_enable,
  input wire logic            rx_enable,
  input wire logic [RI_W-1:0] tx_rate_idx,
  input wire logic [RI_W-1:0] rx_rate_idx,
  input wire logic            hyperframe_lock_state,
  input wire logic            far_hf_lock,
  input wire logic            slave_in_vendor,
  input wire logic            sup_restart
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // sequencing
  property p_reset_idle;
    $rose(nrst) |-> seq_state == 3'h0 && !port_is_master && !tx_enable;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("port not idle slave after reset");
  property p_master_wait;
    (seq_state == 3'h1 && $past(seq_state) == 3'h0 && port_is_master)
      |-> $past(slave_in_vendor);
  endproperty
  a_master_wait: assert property (p_master_wait)
    else $error("master left standby too early");
  property p_master_rate;
    (seq_state == 3'h1 && $stable(seq_state) && port_is_master)
      |-> tx_enable && rx_enable && tx_rate_idx == rx_rate_idx;
  endproperty
  a_master_rate: assert property (p_master_rate)
    else $error("master not on one rate both ways");
  property p_hop_unlocked;
    (seq_state == 3'h1 && $past(seq_state) == 3'h1 && $changed(rx_rate_idx))
      |-> !$past(hyperframe_lock_state);
  endproperty
  a_hop_unlocked: assert property (p_hop_unlocked)
    else $error("rate hop while locked");
  property p_slave_tx_off;
    (seq_state == 3'h1 && !port_is_master && !hyperframe_lock_state)
      |=> !tx_enable;
  endproperty
  a_slave_tx_off: assert property (p_slave_tx_off)
    else $error("slave transmits without lock");
  property p_sync_exit;
    (seq_state == 3'h1 && hyperframe_lock_state && far_hf_lock)
      |=> seq_state != 3'h1;
  endproperty
  a_sync_exit: assert property (p_sync_exit)
    else $error("sync held despite two-way lock");
  property p_cm_entry;
    (seq_state == 3'h3 && $past(seq_state) == 3'h2)
      |-> $past(hyperframe_lock_state);
  endproperty
  a_cm_entry: assert property (p_cm_entry)
    else $error("C&M setup entered without lock");
  property p_sup_expiry;
    sup_restart |-> seq_state == 3'h1 && $past(seq_state) >= 3'h2;
  endproperty
  a_sup_expiry: assert property (p_sup_expiry)
    else $error("bad supervision restart");
  c_vendor: cover property (seq_state == 3'h4);
  c_restart: cover property (sup_restart);
  c_master_proto: cover property (port_is_master && seq_state == 3'h2);
endmodule // startup_seq_properties
`default_nettype wire

// ===== verif/peer_port_model.sv
// Purpose: behavioural peer port and phy facing the sequencer
// Assumes: lock only while our receiver sits on the peer's rate
// Notes:   version line toggles while unlocked, no stale value
`timescale 1ns/1ps
`default_nettype none
module peer_port_model
  import startup_seq_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            nrst,
  input  wire logic            tx_enable,
  input  wire logic            rx_enable,
  input  wire logic [RI_W-1:0] rx_rate_idx,
  input  wire logic [RI_W-1:0] peer_rate,
  input  wire logic [7:0]      peer_ver,
  output logic                 hyperframe_lock_state,
  output logic                 far_hf_lock,
  output logic                 rx_hf_strobe,
  output logic [7:0]           rx_version
);
  logic [1:0] frame_cnt;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      {hyperframe_lock_state, far_hf_lock, rx_hf_strobe} <= 3'h0;
      frame_cnt  <= 2'h0;
      rx_version <= 8'h00;
    end else begin
      // lock well inside the allowed time
      hyperframe_lock_state <= rx_enable && rx_rate_idx == peer_rate;
      far_hf_lock  <= hyperframe_lock_state && tx_enable;
      frame_cnt    <= frame_cnt + 2'h1;
      rx_hf_strobe <= hyperframe_lock_state && frame_cnt == 2'h0;
      rx_version   <= hyperframe_lock_state ? peer_ver : ~rx_version;
    end
  end
endmodule // peer_port_model
`default_nettype wire

// ===== verif/tb_radio_link_startup_sequencer.sv
// Purpose: self-checking bench for the start-up sequencer
// Assumes: shortened dwell, eval and supervision counts
// Notes:   masks 0x7 rates, 0xF then 0xC versions
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_radio_link_startup_sequencer
  import startup_seq_pkg::*;
;
  localparam int MD = 40;
  localparam int SD = 100;
  localparam int ST = 2000;
  logic              sys_clk, nrst, hyperframe_lock_state, far_hf_lock;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, rx_hf_strobe, slave_in_vendor;
  logic              cm_rate_agreed, cm_link_up, tx_enable, rx_enable;
  logic              port_is_master, sup_restart;
  logic [RI_W-1:0]   tx_rate_idx, rx_rate_idx, peer_rate, rate_now;
  logic [7:0]        rx_version, tx_version, peer_ver;
  logic [2:0]        tx_hdlc_rate, seq_state;
  logic [5:0]        tx_eth_rate;
  logic [2:0]        hops [3] = '{3'h1, 3'h0, 3'h2};
  int                failures = 0, compares = 0, sup_seen = 0;
  startup_seq #(.MASTER_DWELL(MD), .SLAVE_DWELL(SD), .EVAL_PERIOD(8),
    .SUP_TIMEOUT(ST)) startup_seq_inst (
    .sys_clk(sys_clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .hyperframe_lock_state(hyperframe_lock_state),
    .far_hf_lock(far_hf_lock), .rx_hf_strobe(rx_hf_strobe),
    .rx_version(rx_version), .slave_in_vendor(slave_in_vendor),
    .cm_rate_agreed(cm_rate_agreed), .cm_link_up(cm_link_up),
    .tx_enable(tx_enable), .rx_enable(rx_enable),
    .tx_rate_idx(tx_rate_idx), .rx_rate_idx(rx_rate_idx),
    .tx_version(tx_version), .tx_hdlc_rate(tx_hdlc_rate),
    .tx_eth_rate(tx_eth_rate), .seq_state(seq_state),
    .port_is_master(port_is_master), .sup_restart(sup_restart));
  peer_port_model peer_port_model_inst (
    .sys_clk(sys_clk), .nrst(nrst), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .rx_rate_idx(rx_rate_idx),
    .peer_rate(peer_rate), .peer_ver(peer_ver),
    .hyperframe_lock_state(hyperframe_lock_state),
    .far_hf_lock(far_hf_lock), .rx_hf_strobe(rx_hf_strobe),
    .rx_version(rx_version));
  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    s_axi_rready <= 1'h0;
    `CHK("rdata", ed, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  // bounded wait, the compare catches a miss
  task automatic wait_st(input logic [2:0] s, input int lim);
    for (int i = 0; i < lim && seq_state !== s; i++) @(posedge sys_clk);
    `CHK("state", s, seq_state)
  endtask
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, restart monitor
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    stop_test();
  end
  always @(posedge sys_clk) if (sup_restart === 1'h1) sup_seen <= sup_seen + 1;
  // ==========================================================
  // tests
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, slave_in_vendor} = 3'h0;
    {cm_rate_agreed, cm_link_up, peer_rate, peer_ver} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'h1;
    `CHK("role", 1'h0, port_is_master)
    rd(A_CTRL, 32'h0, RESP_OKAY);
    rd(A_RATEMASK, 32'h1, RESP_OKAY);
    rd(A_VERMASK, 32'h1, RESP_OKAY);
    rd(A_STATUS, 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h0, RESP_SLVERR);
    wr(A_RESTARTS, 32'hFF, RESP_OKAY);
    rd(A_RESTARTS, 32'h0, RESP_OKAY);
    $display("test reset done");
    peer_rate <= 3'h1;
    peer_ver <= 8'h03;
    wr(A_RATEMASK, 32'h7, RESP_OKAY);
    wr(A_VERMASK, 32'hF, RESP_OKAY);
    wr(A_CMRATES, 32'h2A05, RESP_OKAY);
    `CHK("cm", 9'h16A, {tx_hdlc_rate, tx_eth_rate})
    wr(A_CTRL, 32'h1, RESP_OKAY);
    wait_st(3'h1, 10);
    `CHK("rx_rate", 3'h2, rx_rate_idx)
    `CHK("tx_en", 1'h0, tx_enable)
    `CHK("tx_ver", 8'h04, tx_version)
    wait_st(3'h2, 2 * SD);
    `CHK("rx_rate", 3'h1, rx_rate_idx)
    `CHK("tx_en", 1'h1, tx_enable)
    wait_st(3'h3, 100);
    `CHK("tx_ver", 8'h03, tx_version)
    cm_rate_agreed <= 1'h1;
    wait_st(3'h4, 10);
    $display("test slave done");
    for (int i = 0; i < ST + 50 && sup_seen == 0; i++) @(posedge sys_clk);
    `CHK("restart", 1, sup_seen)
    wait_st(3'h4, 200);
    rd(A_RESTARTS, 32'h1, RESP_OKAY);
    cm_link_up <= 1'h1;
    repeat (ST + 100) @(posedge sys_clk);
    `CHK("restart", 1, sup_seen)
    $display("test supervision done");
    wr(A_CTRL, 32'h0, RESP_OKAY);
    wait_st(3'h0, 10);
    `CHK("en", 2'h0, {tx_enable, rx_enable})
    {cm_link_up, cm_rate_agreed, peer_rate, peer_ver} <= {2'h0, 3'h7, 8'h02};
    wr(A_VERMASK, 32'hC, RESP_OKAY);
    wr(A_CTRL, 32'h3, RESP_OKAY);
    repeat (5) @(posedge sys_clk);
    `CHK("state", 3'h0, seq_state)
    slave_in_vendor <= 1'h1;
    wait_st(3'h1, 10);
    `CHK("en", 2'h3, {tx_enable, rx_enable})
    `CHK("tx_rate", 3'h2, tx_rate_idx)
    `CHK("tx_ver", 8'h04, tx_version)
    for (int i = 0; i < 3; i++) begin
      rate_now = tx_rate_idx;
      for (int n = 0; n < 2 * MD && tx_rate_idx === rate_now; n++)
        @(posedge sys_clk);
      `CHK("hop", hops[i], tx_rate_idx)
    end
    peer_rate <= 3'h2;
    wait_st(3'h2, 20);
    `CHK("tx_ver", 8'h04, tx_version)
    repeat (40) @(posedge sys_clk);
    `CHK("tx_ver", 8'h03, tx_version)
    peer_ver <= 8'h04;
    wait_st(3'h3, 60);
    `CHK("tx_ver", 8'h04, tx_version)
    $display("test master done");
    stop_test();
  end
endmodule // tb_radio_link_startup_sequencer
bind startup_seq startup_seq_properties startup_seq_properties_inst (
  .sys_clk(sys_clk), .nrst(nrst), .seq_state(seq_state),
  .port_is_master(port_is_master), .tx_enable(tx_enable),
  .rx_enable(rx_enable), .tx_rate_idx(tx_rate_idx),
  .rx_rate_idx(rx_rate_idx),
  .hyperframe_lock_state(hyperframe_lock_state),
  .far_hf_lock(far_hf_lock), .slave_in_vendor(slave_in_vendor),
  .sup_restart(sup_restart));
`default_nettype wire
